//--- rtl/bfp_pkg.sv
// Purpose: Shared constants and types for the bridge fault protection block
// Assumes: 50 MHz clk
// Notes:   Times in ns, cycle counts derived from the clock period
`default_nettype none
package bfp_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int DEGLITCH_NS   = 1000;
  localparam int DEAD_NS       = 500;
  localparam int OCP_FILT_NS   = 3000;
  localparam int RETRY_NS      = 4000000;
  localparam int WAKE_NS       = 1000;
  localparam int DEGLITCH_CYC  = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_CYC      = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OCP_FILT_CYC  = (OCP_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_CYC     = (RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYC      = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [1:0] OCP_LATCHED  = 2'h0;
  localparam logic [1:0] OCP_RETRY    = 2'h1;
  localparam logic [1:0] OCP_REPORT   = 2'h2;
  localparam logic [1:0] OCP_DISABLED = 2'h3;
  localparam logic [1:0] MODE_INDEP   = 2'h2;
  localparam logic [1:0] OCP_RESET_POLICY = OCP_LATCHED;

  localparam logic [2:0] SLEW_FASTEST = 3'h0;
  localparam logic [2:0] SLEW_13      = 3'h3;
  localparam logic [2:0] SLEW_SLOWEST = 3'h7;

  // Strap levels of the slew pin
  localparam logic [1:0] STRAP_GND  = 2'h0;
  localparam logic [1:0] STRAP_OPEN = 2'h1;
  localparam logic [1:0] STRAP_VDD  = 2'h2;

  typedef struct packed {
    logic summary;
    logic supplyUv;
    logic pumpUv;
    logic ocp;
    logic [3:0] fetOcp;
  } bfp_status_t;

  typedef struct packed {
    logic hiOn;
    logic loOn;
  } bfp_gate_t;
endpackage
`default_nettype wire

//--- rtl/bfp_deglitch.sv
// Purpose: Input synchroniser and deglitch filter
// Assumes: Input from outside the clock domain
// Notes:   Output changes only after a stable run of DEPTH cycles
`default_nettype none
module bfp_deglitch
  import bfp_pkg::*;
#(
  parameter int DEPTH = DEGLITCH_CYC
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic rawIn,
  output logic      cleanOut
);
  logic       sync1_ff;
  logic       sync2_ff;
  logic [7:0] cnt_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= rawIn;
      sync2_ff <= sync1_ff;
    end
  end

  // Count cycles the input differs from the output, reset when they match
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_ff   <= 8'h00;
      cleanOut <= 1'b0;
    end else if (sync2_ff == cleanOut) begin
      cnt_ff <= 8'h00;
    end else if (cnt_ff >= 8'(DEPTH - 1)) begin
      cnt_ff   <= 8'h00;
      cleanOut <= sync2_ff;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  property p_glitch_ignored;
    @(posedge clk) disable iff (sys_rst)
      $changed(cleanOut) |-> $past(sync2_ff) == cleanOut;
  endproperty
  a_glitch_ignored: assert property (p_glitch_ignored) else $error("deglitch output took unsettled value");
endmodule
`default_nettype wire

//--- rtl/bfp_half_bridge.sv
// Purpose: One half-bridge gate sequencer with dead time
// Assumes: cmdHigh already deglitched
// Notes:   Both gates off for DEAD cycles on every change
`default_nettype none
module bfp_half_bridge
  import bfp_pkg::*;
#(
  parameter int DEAD = DEAD_CYC
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic enable,
  input  wire logic cmdHigh,
  output bfp_gate_t gate
);
  typedef enum logic [1:0] {HB_OFF = 2'b00, HB_DEAD = 2'b01, HB_ON = 2'b11} bfp_hb_t;
  bfp_hb_t    st_ff;
  logic       side_ff;
  logic [7:0] dcnt_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff   <= HB_OFF;
      side_ff <= 1'b0;
      dcnt_ff <= 8'h00;
    end else if (!enable) begin
      st_ff <= HB_OFF;
    end else begin
      unique case (st_ff)
        HB_OFF: begin
          st_ff   <= HB_DEAD;
          side_ff <= cmdHigh;
          dcnt_ff <= 8'h00;
        end
        HB_DEAD: begin
          if (side_ff != cmdHigh) begin
            side_ff <= cmdHigh;
            dcnt_ff <= 8'h00;
          end else if (dcnt_ff >= 8'(DEAD - 1)) begin
            st_ff <= HB_ON;
          end else begin
            dcnt_ff <= dcnt_ff + 8'h01;
          end
        end
        HB_ON: begin
          if (side_ff != cmdHigh) begin
            st_ff   <= HB_DEAD;
            side_ff <= cmdHigh;
            dcnt_ff <= 8'h00;
          end
        end
        default: st_ff <= HB_OFF;
      endcase
    end
  end

  // Gates registered from state flops, enable and command
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gate <= '0;
    end else begin
      gate.hiOn <= enable && st_ff == HB_ON && side_ff && cmdHigh;
      gate.loOn <= enable && st_ff == HB_ON && !side_ff && !cmdHigh;
    end
  end

  property p_no_overlap;
    @(posedge clk) disable iff (sys_rst) !(gate.hiOn && gate.loOn);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both gates on");

  property p_off_before_on;
    @(posedge clk) disable iff (sys_rst)
      $rose(gate.hiOn) |-> $past(!gate.loOn, 1) && $past(!gate.loOn, 2);
  endproperty
  a_off_before_on: assert property (p_off_before_on) else $error("high side on without dead time");
endmodule
`default_nettype wire

//--- rtl/bfp_top.sv
// Purpose: Bridge fault protection, fault reporting and gate sequencing
// Assumes: Analog comparators give level fault indications; one clock
// Notes:   Sleep input low acts as reset of the fault logic
// What this block does
// - Three-bit slew code, 000 fastest, 111 slowest
// - Strap: ground fastest, open 13, logic supply slowest
// - Output high impedance between transistor switchovers
// - Drive inputs pass a deglitch filter
// - Conducting transistor turned off before opposite on
// - Fault output low whenever fault present
// - Fault output low until core operational
// - Sleep low sleeps, rising edge wakes
// - No serial output while sleep low
// - Supply undervoltage: outputs off, pump off, latch
// - Supply undervoltage recovers alone, bit stays sticky
// - Pump undervoltage: outputs off, pump on, latch
// - Pump undervoltage disable bit suppresses protection
// - Filtered overcurrent disables that half-bridge
// - Two-bit overcurrent policy selects four behaviours
// - Independent mode handles each half-bridge separately
// - Latched: off until condition gone and cleared
// - Latched policy is the reset default
// - Retry: resume after interval and fault gone
// - Clear command or sleep pulse clears bits
// - Report only: keep driving, report until cleared
// - Disabled: no action, keep driving
`default_nettype none
module bfp_top
  import bfp_pkg::*;
#(
  parameter int RETRY = RETRY_CYC,
  parameter int FILT  = OCP_FILT_CYC,
  parameter int WAKE  = WAKE_CYC
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       sleep_in_n,
  input  wire logic [1:0] drive_input,
  input  wire logic       supply_undervoltage,
  input  wire logic       pump_undervoltage,
  input  wire logic [3:0] fetOvercurrent,
  input  wire logic       pump_uv_disable,
  input  wire logic       clear_faults_cmd,
  input  wire logic [1:0] ocpPolicy,
  input  wire logic       ocpPolicyValid,
  input  wire logic [1:0] bridgeMode,
  input  wire logic       strapVariant,
  input  wire logic [2:0] slewCode,
  input  wire logic [1:0] slewStrap,
  output bfp_gate_t [1:0] bridge_output,
  output logic            pumpEnable,
  output logic [2:0]      slew_select,
  output logic            fault_out_n_o,
  output logic            fault_out_n_oe,
  output logic            serialOutEnable,
  output bfp_status_t     status
);
  logic       slp1_ff;
  logic       slp2_ff;
  logic       awake_ff;
  logic       coreReady_ff;
  logic [7:0] wakeCnt_ff;
  logic       intRst;
  logic [1:0] ocpMode_ff;
  logic [1:0] cleanIn;
  logic [1:0] ocLvl;
  logic [1:0] ocFilt;
  logic [1:0] ocLatched_ff;
  logic [1:0] bridgeEn;
  logic       globalOff;
  logic       pumpUvAct;
  logic       clearNow;
  logic [1:0] ocpActive;
  logic       ocpFaultShown;
  logic [1:0] strap1_ff;
  logic [1:0] strap2_ff;

  // Sleep and strap pin synchronisers, wake sequencing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slp1_ff   <= 1'b0;
      slp2_ff   <= 1'b0;
      strap1_ff <= 2'h0;
      strap2_ff <= 2'h0;
    end else begin
      slp1_ff   <= sleep_in_n;
      slp2_ff   <= slp1_ff;
      strap1_ff <= slewStrap;
      strap2_ff <= strap1_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awake_ff <= 1'b0;
    end else begin
      awake_ff <= slp2_ff;
    end
  end

  assign intRst = sys_rst || !slp2_ff;

  always_ff @(posedge clk) begin
    if (intRst) begin
      wakeCnt_ff   <= 8'h00;
      coreReady_ff <= 1'b0;
    end else if (wakeCnt_ff >= 8'(WAKE - 1)) begin
      coreReady_ff <= 1'b1;
    end else begin
      wakeCnt_ff <= wakeCnt_ff + 8'h01;
    end
  end

  // Policy register, latched after reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ocpMode_ff <= OCP_RESET_POLICY;
    end else if (ocpPolicyValid && !strapVariant) begin
      ocpMode_ff <= ocpPolicy;
    end
  end

  // Slew code from register or strap
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slew_select <= SLEW_FASTEST;
    end else if (!strapVariant) begin
      slew_select <= slewCode;
    end else begin
      unique case (strap2_ff)
        STRAP_GND:  slew_select <= SLEW_FASTEST;
        STRAP_OPEN: slew_select <= SLEW_13;
        STRAP_VDD:  slew_select <= SLEW_SLOWEST;
        default:    slew_select <= SLEW_13;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_in
      bfp_deglitch u_dg (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .rawIn    (drive_input[gi]),
        .cleanOut (cleanIn[gi])
      );
    end
  endgenerate

  // Overcurrent sync and filter, per half-bridge
  logic [3:0] oc1_ff;
  logic [3:0] oc2_ff;
  logic [7:0]  fcnt_ff [2];
  logic [31:0] rcnt_ff [2];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      oc1_ff <= 4'h0;
      oc2_ff <= 4'h0;
    end else begin
      oc1_ff <= fetOvercurrent;
      oc2_ff <= oc1_ff;
    end
  end

  assign ocLvl[0] = oc2_ff[0] | oc2_ff[1];
  assign ocLvl[1] = oc2_ff[2] | oc2_ff[3];
  assign clearNow = clear_faults_cmd;
  assign pumpUvAct = pump_undervoltage && !pump_uv_disable;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_oc
      always_ff @(posedge clk) begin
        if (intRst || ocpMode_ff == OCP_DISABLED) begin
          fcnt_ff[gi] <= 8'h00;
        end else if (!ocLvl[gi]) begin
          fcnt_ff[gi] <= 8'h00;
        end else if (fcnt_ff[gi] < 8'(FILT)) begin
          fcnt_ff[gi] <= fcnt_ff[gi] + 8'h01;
        end
      end
      assign ocFilt[gi] = fcnt_ff[gi] >= 8'(FILT);

      // Retry interval counter
      always_ff @(posedge clk) begin
        if (intRst || !ocLatched_ff[gi]) begin
          rcnt_ff[gi] <= 32'h0000_0000;
        end else if (rcnt_ff[gi] < 32'(RETRY)) begin
          rcnt_ff[gi] <= rcnt_ff[gi] + 32'h0000_0001;
        end
      end

      // Protective latch per half-bridge, set wins over release
      always_ff @(posedge clk) begin
        if (intRst) begin
          ocLatched_ff[gi] <= 1'b0;
        end else if (ocFilt[gi] && ocpMode_ff != OCP_DISABLED) begin
          ocLatched_ff[gi] <= 1'b1;
        end else if (ocpMode_ff == OCP_RETRY) begin
          if (rcnt_ff[gi] >= 32'(RETRY) && !ocLvl[gi])
            ocLatched_ff[gi] <= 1'b0;
        end else if (ocpMode_ff == OCP_DISABLED) begin
          ocLatched_ff[gi] <= 1'b0;
        end else if (clearNow && !ocLvl[gi]) begin
          ocLatched_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Shutdown only for latched and retry policies
  always_comb begin
    ocpActive = ocLatched_ff & {2{ocpMode_ff == OCP_LATCHED || ocpMode_ff == OCP_RETRY}};
    if (bridgeMode == MODE_INDEP) begin
      bridgeEn = ~ocpActive;
    end else begin
      bridgeEn = {2{~|ocpActive}};
    end
  end

  assign globalOff = supply_undervoltage || pumpUvAct || !coreReady_ff;
  assign ocpFaultShown = |ocLatched_ff;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_hb
      bfp_half_bridge u_hb (
        .clk     (clk),
        .sys_rst (sys_rst),
        .enable  (bridgeEn[gi] && !globalOff && awake_ff),
        .cmdHigh (cleanIn[gi]),
        .gate    (bridge_output[gi])
      );
    end
  endgenerate

  // Sticky status bits; set wins over clear
  always_ff @(posedge clk) begin
    if (intRst) begin
      status <= '0;
    end else begin
      if (supply_undervoltage) status.supplyUv <= 1'b1;
      else if (clearNow) status.supplyUv <= 1'b0;
      if (pumpUvAct) status.pumpUv <= 1'b1;
      else if (clearNow) status.pumpUv <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        if (ocFilt[i / 2] && ocpMode_ff != OCP_DISABLED && oc2_ff[i]) status.fetOcp[i] <= 1'b1;
        else if (clearNow) status.fetOcp[i] <= 1'b0;
      end
      if (|ocFilt && ocpMode_ff != OCP_DISABLED) status.ocp <= 1'b1;
      else if (clearNow) status.ocp <= 1'b0;
      if (supply_undervoltage || pumpUvAct || (|ocFilt && ocpMode_ff != OCP_DISABLED)) status.summary <= 1'b1;
      else if (clearNow) status.summary <= 1'b0;
    end
  end

  // Outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pumpEnable      <= 1'b0;
      fault_out_n_oe  <= 1'b0;
      serialOutEnable <= 1'b0;
    end else begin
      pumpEnable      <= awake_ff && !supply_undervoltage;
      fault_out_n_oe  <= coreReady_ff && !globalOff && !ocpFaultShown;
      serialOutEnable <= slp2_ff;
    end
  end
  assign fault_out_n_o = 1'b0;

  property p_uv_fault;
    @(posedge clk) disable iff (sys_rst)
      supply_undervoltage |-> ##1 !fault_out_n_oe && !pumpEnable;
  endproperty
  a_uv_fault: assert property (p_uv_fault) else $error("supply undervoltage not reported");

  property p_uv_sticky;
    @(posedge clk) disable iff (intRst)
      status.supplyUv && !clearNow |=> status.supplyUv;
  endproperty
  a_uv_sticky: assert property (p_uv_sticky) else $error("undervoltage bit lost");

  property p_pump_undervoltage_pump;
    @(posedge clk) disable iff (sys_rst)
      pumpUvAct && awake_ff && !supply_undervoltage |-> ##1 pumpEnable && !fault_out_n_oe;
  endproperty
  a_pump_undervoltage_pump: assert property (p_pump_undervoltage_pump) else $error("pump undervoltage handling wrong");

  property p_pump_undervoltage_dis;
    @(posedge clk) disable iff (intRst)
      pump_uv_disable && !status.pumpUv |=> !status.pumpUv;
  endproperty
  a_pump_undervoltage_dis: assert property (p_pump_undervoltage_dis) else $error("disabled pump undervoltage latched");

  property p_reset_policy;
    @(posedge clk) $fell(sys_rst) |-> ocpMode_ff == OCP_LATCHED;
  endproperty
  a_reset_policy: assert property (p_reset_policy) else $error("policy not latched after reset");

  property p_disabled_noop;
    @(posedge clk) disable iff (intRst)
      ocpMode_ff == OCP_DISABLED && $past(ocpMode_ff == OCP_DISABLED) |-> ocLatched_ff == 2'b00;
  endproperty
  a_disabled_noop: assert property (p_disabled_noop) else $error("disabled policy took action");

  property p_latched_hold;
    @(posedge clk) disable iff (intRst)
      ocLatched_ff[0] && ocpMode_ff == OCP_LATCHED && !clearNow |=> ocLatched_ff[0];
  endproperty
  a_latched_hold: assert property (p_latched_hold) else $error("latched overcurrent released early");

  property p_sleep_serial;
    @(posedge clk) disable iff (sys_rst) !slp2_ff |=> !serialOutEnable;
  endproperty
  a_sleep_serial: assert property (p_sleep_serial) else $error("serial output during sleep");
endmodule
`default_nettype wire

//--- bench/bfp_host_model.sv
// Purpose: Host side of the fault pin and sleep pin
// Assumes: Fault line pulled up, open drain
// Notes:   Sleep request from the bench, one cycle of pin delay
`default_nettype none
module bfp_host_model (
  input  wire logic clk,
  input  wire logic sleepReq,
  input  wire logic faultDrive,
  input  wire logic faultOe,
  output var logic  sleepN,
  output logic      faultPinN,
  output var logic  coreReady
);
  timeunit 1ns;
  timeprecision 1ns;
  initial sleepN = 1'b1;
  initial coreReady = 1'b0;
  // Pin high while output enable set, else follows the drive value
  assign faultPinN = faultOe ? 1'b1 : faultDrive;
  // Sleep only when asked, clearing uses the clear bit
  always @(posedge clk) sleepN <= ~sleepReq;
  // Low after wake means not ready yet
  always @(posedge clk) begin
    if (!sleepN) coreReady <= 1'b0;
    else if (faultPinN) coreReady <= 1'b1;
  end
endmodule
`default_nettype wire

//--- bench/tb.sv
// Purpose: Self-checking bench of the bridge fault protection
// Assumes: Short filter, retry and wake counts
// Notes:   Slew rows in a table, fault cases by hand
`default_nettype none
module tb
  import bfp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FILT_T = 10;
  localparam int RETRY_T = 20;
  localparam int WAKE_T = 8;
  localparam int GLAT = DEGLITCH_CYC + DEAD_CYC + 8;
  localparam bfp_gate_t GHI = 2'h2;
  localparam bfp_gate_t GLO = 2'h1;
  localparam bfp_gate_t GOFF = 2'h0;
  typedef struct packed {logic strap; logic [2:0] code; logic [1:0] pin; logic [2:0] exp;} bfp_row_t;
  localparam bfp_row_t ROWS [12] = '{
    '{1'b0, 3'h0, 2'h2, 3'h0}, '{1'b0, 3'h1, 2'h2, 3'h1}, '{1'b0, 3'h2, 2'h2, 3'h2},
    '{1'b0, 3'h3, 2'h2, 3'h3}, '{1'b0, 3'h4, 2'h2, 3'h4}, '{1'b0, 3'h5, 2'h2, 3'h5},
    '{1'b0, 3'h6, 2'h2, 3'h6}, '{1'b0, 3'h7, 2'h2, 3'h7}, '{1'b1, 3'h7, STRAP_GND, SLEW_FASTEST},
    '{1'b1, 3'h0, STRAP_OPEN, SLEW_13}, '{1'b1, 3'h0, STRAP_VDD, SLEW_SLOWEST},
    '{1'b1, 3'h0, 2'h3, SLEW_13}};
  logic clk, sysRst, sleepReq, sleepN, supplyUv, pumpUv, pumpUvDis, clrCmd, policyValid, strapVar;
  logic [1:0] driveIn, policy, mode, slewStrapIn;
  logic [3:0] fetOc;
  logic [2:0] slewCodeIn, slewSel;
  logic pumpEn, faultO, faultOe, serOe, faultPinN, coreReady;
  bfp_gate_t [1:0] gates;
  bfp_gate_t prevGate [2];
  bfp_status_t stat;
  int errorCnt = 0;
  int checked = 0;
  bfp_top #(.RETRY(RETRY_T), .FILT(FILT_T), .WAKE(WAKE_T)) dut (
    .clk(clk), .sys_rst(sysRst), .sleep_in_n(sleepN), .drive_input(driveIn),
    .supply_undervoltage(supplyUv), .pump_undervoltage(pumpUv), .fetOvercurrent(fetOc),
    .pump_uv_disable(pumpUvDis), .clear_faults_cmd(clrCmd), .ocpPolicy(policy),
    .ocpPolicyValid(policyValid), .bridgeMode(mode), .strapVariant(strapVar), .slewCode(slewCodeIn),
    .slewStrap(slewStrapIn), .bridge_output(gates), .pumpEnable(pumpEn), .slew_select(slewSel),
    .fault_out_n_o(faultO), .fault_out_n_oe(faultOe), .serialOutEnable(serOe), .status(stat));
  bfp_host_model host (.clk(clk), .sleepReq(sleepReq), .faultDrive(faultO), .faultOe(faultOe),
    .sleepN(sleepN), .faultPinN(faultPinN), .coreReady(coreReady));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic fail(input string m);
    errorCnt++;
    $display("mismatch t=%0t %s", $time, m);
  endtask
  task automatic chkBit(input logic got, input logic exp, input string m);
    #1 checked++;
    if (got !== exp) fail(m);
  endtask
  task automatic chkGate(input bfp_gate_t got, input bfp_gate_t exp, input string m);
    #1 checked++;
    if (got !== exp) fail(m);
  endtask
  task automatic chkSlew(input logic [2:0] got, input logic [2:0] exp);
    #1 checked++;
    if (got !== exp) fail("slew code");
  endtask
  task automatic chkStat(input bfp_status_t got, input logic [7:0] exp);
    #1 checked++;
    if (got !== bfp_status_t'(exp)) fail("status bits");
  endtask
  task automatic clearFaults();
    @(posedge clk) clrCmd <= 1'b1;
    @(posedge clk) clrCmd <= 1'b0;
    cyc(3);
  endtask
  task automatic completeRun();
    $display("checks %0d mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Never both on, never a direct swap
  always @(negedge clk) begin
    for (int b = 0; b < 2; b++) begin
      if (!sysRst && gates[b] === 2'h3) fail("shoot through");
      if (!sysRst && gates[b] !== prevGate[b] && gates[b] !== GOFF && prevGate[b] !== GOFF)
        fail("no dead time");
      prevGate[b] = gates[b];
    end
  end
  initial begin
    cyc(20000);
    fail("watchdog");
    completeRun();
  end
  initial begin
    sysRst = 1'b1; sleepReq = 1'b0; supplyUv = 1'b0; pumpUv = 1'b0; pumpUvDis = 1'b0; clrCmd = 1'b0;
    policyValid = 1'b0; strapVar = 1'b0; driveIn = 2'h0; policy = 2'h0; mode = 2'h0;
    slewStrapIn = 2'h0; fetOc = 4'h0; slewCodeIn = 3'h0;
    cyc(20);
    sysRst <= 1'b0;
    chkBit(faultPinN, 1'b0, "fault not low at start");
    cyc(WAKE_T + 10);
    chkBit(coreReady, 1'b1, "core not ready");
    chkStat(stat, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      strapVar <= ROWS[i].strap;
      slewCodeIn <= ROWS[i].code;
      slewStrapIn <= ROWS[i].pin;
      cyc(4);
      chkSlew(slewSel, ROWS[i].exp);
    end
    @(posedge clk) strapVar <= 1'b0;
    $display("test slew done");
    @(posedge clk) driveIn <= 2'h1;
    cyc(GLAT);
    chkGate(gates[0], GHI, "bridge0 high");
    chkGate(gates[1], GLO, "bridge1 low");
    @(posedge clk) driveIn <= 2'h0;
    cyc(10);
    driveIn <= 2'h1;
    cyc(GLAT);
    chkGate(gates[0], GHI, "glitch passed");
    @(posedge clk) driveIn <= 2'h0;
    cyc(DEGLITCH_CYC + DEAD_CYC / 2 + 3);
    chkGate(gates[0], GOFF, "no high impedance gap");
    cyc(GLAT);
    chkGate(gates[0], GLO, "bridge0 low");
    @(posedge clk) driveIn <= 2'h1;
    cyc(GLAT);
    $display("test drive done");
    @(posedge clk) supplyUv <= 1'b1;
    cyc(4);
    chkGate(gates[0], GOFF, "supply uv drive");
    chkBit(pumpEn, 1'b0, "pump on in supply uv");
    chkBit(faultPinN, 1'b0, "supply uv fault");
    chkStat(stat, 8'hC0);
    @(posedge clk) supplyUv <= 1'b0;
    cyc(GLAT);
    chkGate(gates[0], GHI, "no resume");
    chkBit(faultPinN, 1'b1, "fault kept");
    chkBit(stat.supplyUv, 1'b1, "bit not sticky");
    clearFaults();
    chkStat(stat, 8'h00);
    for (int d = 1; d >= 0; d--) begin
      @(posedge clk);
      pumpUvDis <= d[0];
      pumpUv <= 1'b1;
      cyc(4);
      chkGate(gates[0], d ? GHI : GOFF, "pump uv drive");
      chkBit(pumpEn, 1'b1, "pump stopped");
      chkBit(faultPinN, d[0], "pump uv fault");
      chkStat(stat, d ? 8'h00 : 8'hA0);
      @(posedge clk) pumpUv <= 1'b0;
      cyc(GLAT);
      chkGate(gates[0], GHI, "pump uv resume");
      chkBit(stat.pumpUv, ~d[0], "pump bit");
      clearFaults();
    end
    $display("test undervoltage done");
    @(posedge clk) fetOc[0] <= 1'b1;
    cyc(FILT_T - 4);
    fetOc[0] <= 1'b0;
    cyc(6);
    chkStat(stat, 8'h00);
    for (int p = 0; p < 4; p++) begin
      if (p != 0) begin
        @(posedge clk) policyValid <= 1'b1;
        policy <= p[1:0];
        @(posedge clk) policyValid <= 1'b0;
      end
      @(posedge clk) fetOc[0] <= 1'b1;
      cyc(FILT_T + 8);
      chkGate(gates[0], p >= 2 ? GHI : GOFF, "ocp bridge0");
      chkGate(gates[1], p >= 2 ? GLO : GOFF, "ocp bridge1");
      chkBit(faultPinN, p == 3, "ocp fault");
      chkStat(stat, p == 3 ? 8'h00 : 8'h91);
      @(posedge clk) fetOc[0] <= 1'b0;
      cyc(RETRY_T + GLAT);
      chkGate(gates[0], p == 0 ? GOFF : GHI, "ocp after removal");
      chkBit(faultPinN, p[0], "fault after removal");
      clearFaults();
      cyc(GLAT);
      chkGate(gates[0], GHI, "ocp after clear");
      chkBit(faultPinN, 1'b1, "fault after clear");
      chkStat(stat, 8'h00);
    end
    $display("test policies done");
    @(posedge clk) policyValid <= 1'b1;
    policy <= OCP_LATCHED;
    mode <= MODE_INDEP;
    @(posedge clk) policyValid <= 1'b0;
    fetOc[2] <= 1'b1;
    cyc(FILT_T + 8);
    chkGate(gates[0], GHI, "other bridge stopped");
    chkGate(gates[1], GOFF, "faulty bridge on");
    chkStat(stat, 8'h94);
    @(posedge clk) fetOc[2] <= 1'b0;
    mode <= 2'h0;
    cyc(4);
    clearFaults();
    chkStat(stat, 8'h00);
    $display("test independent done");
    @(posedge clk) supplyUv <= 1'b1;
    cyc(3);
    supplyUv <= 1'b0;
    cyc(3);
    sleepReq <= 1'b1;
    cyc(5);
    chkBit(serOe, 1'b0, "serial out in sleep");
    chkStat(stat, 8'h00);
    @(posedge clk) sleepReq <= 1'b0;
    cyc(4);
    chkBit(faultPinN, 1'b0, "fault not low on wake");
    cyc(WAKE_T + 10);
    chkBit(coreReady, 1'b1, "not ready after wake");
    chkBit(serOe, 1'b1, "serial out off");
    $display("test sleep done");
    completeRun();
  end
endmodule
`default_nettype wire
